// File: rtl/tsm_core.v
// Timeslot switch memory: mode control, counters, access handshake
`timescale 1ns/1ns
`include "tsm_defines.vh"

// How it works
// - Banked mode splits store, swaps halves per frame
// - Trailing output frame gives next-frame delivery
// - Aligned frames delay output channels 0,1 more
// - Low-delay and banked modes latch read address per timeslot
// - Variable-rate mode acts as low-delay mode
// - Half-rate connect: bidirectional bus, random processor access
// - Half-rate connect reads counter, advancing every two
// - Read ack low with data, released after strobe
// - Write captured three clocks after strobe, then ack
// - Full-rate connect outputs counter word every clock
// - Full-rate connect handshake same as half-rate
// - Sequential mode addresses from 11-bit wrapping counter
// - Sequential: R/W high reads, low writes input
// - Sequential and random: output holds last read word during writes
// - Random mode uses external address, R/W per clock
// - Delay line delay is twice address plus two
// - Delay address latched at strobe fall with select
// - Delay line samples and drives on rising edges
// - Three mode pins select one of eight modes
// - Low-delay: write at counter, read at external address
module tsm_core #(
  parameter DW = `TSM_DATA_W,
  parameter PW = `TSM_ADDR_PIN_W,
  parameter CW = `TSM_CNT_W,
  parameter AW = `TSM_MEM_AW
) (
  input  wire          clk,            // Main clock, 50 MHz
  input  wire          resetn,         // Asynchronous reset, active low
  input  wire          framePulseN,    // Frame pulse pin, active low
  input  wire          modeSelectHi,   // Mode select, most significant
  input  wire          modeSelectMid,  // Mode select, middle
  input  wire          modeSelectLo,   // Mode select, least significant
  input  wire [PW-1:0] addrBus,        // External address pins
  input  wire          readWrite,      // High reads, low writes
  input  wire          chipSelectN,    // Chip select, active low
  input  wire          accessStrobeN,  // Access strobe, active low
  input  wire [DW-1:0] inputBus,       // Input data bus, pin level in
  output reg  [DW-1:0] inputBusOut,    // Input bus driven value
  output reg           inputBusOeN,    // Input bus drive enable, low drives
  output reg  [DW-1:0] outputBus,      // Output data bus
  output reg           transferAckN    // Transfer acknowledge, active low
);

  localparam P_IDLE = 2'h0;
  localparam P_WAIT = 2'h1;
  localparam P_DATA = 2'h2;
  localparam P_ACK  = 2'h3;

  localparam [1:0] LAT_LAST = `TSM_PROC_LAT_CYC - 1;

  // Pin synchroniser: first stage is read only by the second
  wire [`TSM_SYNC_W-1:0] syncIn;
  reg  [`TSM_SYNC_W-1:0] sync1_reg;
  reg  [`TSM_SYNC_W-1:0] sync2_reg;

  assign syncIn = {framePulseN, accessStrobeN, chipSelectN, readWrite,
                   modeSelectHi, modeSelectMid, modeSelectLo,
                   addrBus, inputBus};

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= `TSM_SYNC_RST;
      sync2_reg <= `TSM_SYNC_RST;
    end else begin
      sync1_reg <= syncIn;
      sync2_reg <= sync1_reg;
    end
  end

  wire          fpS   = sync2_reg[38];
  wire          dsS   = sync2_reg[37];
  wire          csS   = sync2_reg[36];
  wire          rwS   = sync2_reg[35];
  wire [2:0]    modeS = sync2_reg[34:32];
  wire [PW-1:0] addrS = sync2_reg[31:16];
  wire [DW-1:0] dinS  = sync2_reg[15:0];

  // Edge detection on synchronised levels
  reg fpPrev_reg;
  reg dsPrev_reg;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fpPrev_reg <= 1'b1;
      dsPrev_reg <= 1'b1;
    end else begin
      fpPrev_reg <= fpS;
      dsPrev_reg <= dsS;
    end
  end

  wire frameStart = fpPrev_reg & ~fpS;
  wire dsFall     = dsPrev_reg & ~dsS;

  // Mode decode
  wire isDm = (modeS == `TSM_MODE_LOW_DELAY) |
              (modeS == `TSM_MODE_BANKED) |
              (modeS == `TSM_MODE_VAR_RATE);
  wire isCm1 = (modeS == `TSM_MODE_HALF_CONN);
  wire isCm2 = (modeS == `TSM_MODE_FULL_CONN);
  wire isCm  = isCm1 | isCm2;
  wire isDl  = (modeS == `TSM_MODE_DELAY_LINE);
  // Data modes and half-rate connect use two clocks per timeslot
  wire halfRate = isDm | isCm1;

  // Internal channel counter and timeslot phase
  reg [CW-1:0] cnt_reg;
  reg          phase_reg;
  reg          bank_reg;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg   <= {CW{1'b0}};
      phase_reg <= 1'b0;
      bank_reg  <= 1'b0;
    end else if (frameStart) begin
      cnt_reg   <= {CW{1'b0}};
      phase_reg <= 1'b0;
      bank_reg  <= ~bank_reg;
    end else begin
      phase_reg <= halfRate ? ~phase_reg : 1'b0;
      if (!halfRate || phase_reg) begin
        cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Read address of a data-mode timeslot, taken at its first edge
  reg [CW-1:0] slotAddr_reg;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slotAddr_reg <= {CW{1'b0}};
    end else if (halfRate && !phase_reg) begin
      slotAddr_reg <= addrS[CW-1:0];
    end
  end

  // Delay line write pointer and latched delay setting
  reg [AW-1:0] dlPtr_reg;
  reg [CW-1:0] dlAddr_reg;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dlPtr_reg  <= {AW{1'b0}};
      dlAddr_reg <= {CW{1'b0}};
    end else begin
      dlPtr_reg <= dlPtr_reg + {{(AW-1){1'b0}}, 1'b1};
      if (isDl && dsFall && !csS) begin
        dlAddr_reg <= addrS[CW-1:0];
      end
    end
  end

  // Lag between write and read pointer is twice the setting; the
  // pipeline supplies the remaining two cycles.
  wire [AW-1:0] dlLag    = {dlAddr_reg, 1'b0};
  wire          dlBypass = isDl && (dlAddr_reg == {CW{1'b0}});

  // Processor handshake state
  reg [1:0] pState_reg;
  reg [1:0] waitCnt_reg;
  reg       procRdPend_reg;

  wire latchNow = (pState_reg == P_WAIT) && (waitCnt_reg == LAT_LAST);
  wire procWr   = latchNow && !rwS && isCm;
  wire procRd   = latchNow && rwS && isCm;

  // Shared memory port steering
  reg          wrEn;
  reg [AW-1:0] wrAddr;
  reg [DW-1:0] wrData;
  reg          rdEnA;
  reg [AW-1:0] rdAddrA;
  wire [DW-1:0] qA;
  wire [DW-1:0] qB;

  always @* begin
    wrEn    = 1'b0;
    wrAddr  = {AW{1'b0}};
    wrData  = dinS;
    rdEnA   = 1'b0;
    rdAddrA = {AW{1'b0}};
    case (modeS)
      `TSM_MODE_LOW_DELAY, `TSM_MODE_VAR_RATE: begin
        wrEn    = phase_reg;
        wrAddr  = {1'b0, cnt_reg};
        rdEnA   = phase_reg;
        rdAddrA = {1'b0, slotAddr_reg};
      end
      `TSM_MODE_BANKED: begin
        wrEn    = phase_reg;
        wrAddr  = {1'b0, bank_reg, cnt_reg[CW-2:0]};
        rdEnA   = phase_reg;
        rdAddrA = {1'b0, ~bank_reg, slotAddr_reg[CW-2:0]};
      end
      `TSM_MODE_HALF_CONN: begin
        wrEn    = procWr;
        wrAddr  = {1'b0, addrS[CW-1:0]};
        rdEnA   = phase_reg;
        rdAddrA = {1'b0, cnt_reg};
      end
      `TSM_MODE_FULL_CONN: begin
        wrEn    = procWr;
        wrAddr  = {1'b0, addrS[CW-1:0]};
        rdEnA   = 1'b1;
        rdAddrA = {1'b0, cnt_reg};
      end
      `TSM_MODE_SEQUENTIAL: begin
        wrEn    = ~rwS;
        wrAddr  = {1'b0, cnt_reg};
        rdEnA   = rwS;
        rdAddrA = {1'b0, cnt_reg};
      end
      `TSM_MODE_RANDOM: begin
        wrEn    = ~rwS;
        wrAddr  = {1'b0, addrS[CW-1:0]};
        rdEnA   = rwS;
        rdAddrA = {1'b0, addrS[CW-1:0]};
      end
      `TSM_MODE_DELAY_LINE: begin
        wrEn    = 1'b1;
        wrAddr  = dlPtr_reg;
        rdEnA   = 1'b1;
        rdAddrA = dlPtr_reg - dlLag;
      end
      default: begin
        wrEn = 1'b0;
      end
    endcase
  end

  tsm_mem #(
    .DW (DW),
    .AW (AW)
  ) uMem (
    .clk     (clk),
    .wrEn    (wrEn),
    .wrAddr  (wrAddr),
    .wrData  (wrData),
    .rdAddrA (rdAddrA),
    .rdDataA (qA),
    .rdAddrB ({1'b0, addrS[CW-1:0]}),
    .rdDataB (qB)
  );

  // Output stage: updates only after a read, so writes leave the
  // previous read word standing on the bus.
  reg          rdPend_reg;
  reg          bypass_reg;
  reg [DW-1:0] bypData_reg;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdPend_reg  <= 1'b0;
      bypass_reg  <= 1'b0;
      bypData_reg <= {DW{1'b0}};
      outputBus   <= {DW{1'b0}};
    end else begin
      rdPend_reg  <= rdEnA;
      bypass_reg  <= rdEnA && dlBypass;
      bypData_reg <= dinS;
      if (rdPend_reg) begin
        // Zero lag reads the word written on the same edge
        outputBus <= bypass_reg ? bypData_reg : qA;
      end
    end
  end

  // Processor access: strobe seen low, wait, act, ack, await release
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pState_reg     <= P_IDLE;
      waitCnt_reg    <= 2'h0;
      procRdPend_reg <= 1'b0;
      transferAckN   <= 1'b1;
      inputBusOut    <= {DW{1'b0}};
      inputBusOeN    <= 1'b1;
    end else begin
      case (pState_reg)
        P_IDLE: begin
          waitCnt_reg <= 2'h0;
          if (isCm && !csS && !dsS) begin
            pState_reg <= P_WAIT;
          end
        end
        P_WAIT: begin
          waitCnt_reg <= waitCnt_reg + 2'h1;
          if (latchNow) begin
            procRdPend_reg <= procRd;
            pState_reg     <= P_DATA;
          end
        end
        P_DATA: begin
          if (procRdPend_reg) begin
            inputBusOut <= qB;
            inputBusOeN <= 1'b0;
          end
          transferAckN <= 1'b0;
          pState_reg   <= P_ACK;
        end
        P_ACK: begin
          if (dsS) begin
            transferAckN   <= 1'b1;
            inputBusOeN    <= 1'b1;
            procRdPend_reg <= 1'b0;
            pState_reg     <= P_IDLE;
          end
        end
        default: begin
          pState_reg <= P_IDLE;
        end
      endcase
    end
  end

endmodule

// File: shared/tsm_defines.vh
// Constants for the timeslot switch memory block
`ifndef TSM_DEFINES_VH
`define TSM_DEFINES_VH

// Mode select codes {hi, mid, lo}
`define TSM_MODE_LOW_DELAY   3'h0
`define TSM_MODE_BANKED      3'h1
`define TSM_MODE_HALF_CONN   3'h2
`define TSM_MODE_FULL_CONN   3'h3
`define TSM_MODE_SEQUENTIAL  3'h4
`define TSM_MODE_RANDOM      3'h5
`define TSM_MODE_DELAY_LINE  3'h6
`define TSM_MODE_VAR_RATE    3'h7

// Widths
`define TSM_DATA_W           16
`define TSM_ADDR_PIN_W       16
`define TSM_CNT_W            11
`define TSM_MEM_AW           12

// Processor handshake: cycles from strobe seen low to data capture
`define TSM_PROC_LAT_CYC     3

// Delay line: delay = 2 * address + offset, capped at the maximum
`define TSM_DL_OFFSET_CYC    2
`define TSM_DL_MAX_CYC       4096

// Reset value of the pin synchroniser: strobes, select, frame and R/W high
`define TSM_SYNC_W           39
`define TSM_SYNC_RST         39'h7800000000

`endif

// File: rtl/tsm_mem.v
// Storage array with one write port and two read-first read ports
`timescale 1ns/1ns
module tsm_mem #(
  parameter DW = 16,
  parameter AW = 12
) (
  input  wire          clk,      // Main clock
  input  wire          wrEn,     // Write enable
  input  wire [AW-1:0] wrAddr,   // Write address
  input  wire [DW-1:0] wrData,   // Write data
  input  wire [AW-1:0] rdAddrA,  // Stream read address
  output reg  [DW-1:0] rdDataA,  // Stream read data, one clock later
  input  wire [AW-1:0] rdAddrB,  // Processor read address
  output reg  [DW-1:0] rdDataB   // Processor read data, one clock later
);

  reg [DW-1:0] store [0:(1<<AW)-1];

  // Read-first: a read of the address being written returns the old word
  always @(posedge clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
    rdDataA <= store[rdAddrA];
    rdDataB <= store[rdAddrB];
  end

endmodule

// File: test/tsm_proc_model.sv
// Processor model: strobe and acknowledge bus master for the switch memory
`timescale 1ns/1ns
module tsm_proc_model (
  input  wire        clk,           // Clock
  input  wire        transferAckN,  // Acknowledge
  input  wire [15:0] busIn,         // Bus level
  output reg         chipSelectN,   // Select
  output reg         accessStrobeN, // Strobe
  output reg         readWrite,     // High reads
  output reg  [15:0] addrBus,       // Address
  output reg  [15:0] dataOut,       // Write data
  output reg         dataDrvN       // Low drives data
);
  integer n;
  initial begin
    {chipSelectN, accessStrobeN, readWrite, dataDrvN} = 4'hf;
    {addrBus, dataOut} = 32'h0;
  end
  task pins(input cs, ds, rw, input [15:0] a);
    begin
      @(posedge clk);
      #1;
      {chipSelectN, accessStrobeN, readWrite, addrBus} = {cs, ds, rw, a};
    end
  endtask
  // Qualifiers held up to the acknowledge edge; hold gives a slow release
  task access(input rw, input [15:0] a, d, input integer hold,
              output [15:0] q, output ok);
    begin
      pins(1'b0, 1'b0, rw, a);
      {dataOut, dataDrvN} = {d, rw};
      {q, ok} = 17'h0;
      for (n = 0; n < 20 && !ok; n = n + 1) begin
        @(posedge clk);
        if (transferAckN === 1'b0)
          {q, ok} = {busIn, 1'b1};
      end
      repeat (hold) @(posedge clk);
      #1;
      {chipSelectN, accessStrobeN, dataDrvN} = 3'h7;
      for (n = 0; n < 20 && transferAckN !== 1'b1; n = n + 1)
        @(posedge clk);
    end
  endtask
endmodule

// File: test/tsm_core_checker.sv
// Port checker for the switch memory core
`timescale 1ns/1ns
module tsm_core_checker (
  input wire        clk,           // Clock
  input wire        resetn,        // Reset
  input wire        framePulseN,   // Frame
  input wire        modeSelectHi,  // Mode
  input wire        modeSelectMid, // Mode
  input wire        modeSelectLo,  // Mode
  input wire [15:0] addrBus,       // Address
  input wire        readWrite,     // Read level
  input wire        chipSelectN,   // Select
  input wire        accessStrobeN, // Strobe
  input wire [15:0] inputBus,      // Bus level
  input wire [15:0] inputBusOut,   // Bus drive
  input wire        inputBusOeN,   // Bus enable
  input wire [15:0] outputBus,     // Output
  input wire        transferAckN   // Acknowledge
);
  wire [2:0] mode = {modeSelectHi, modeSelectMid, modeSelectLo};
  wire       conn = mode == 3'h2 || mode == 3'h3;
  wire       req  = !chipSelectN && conn;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_ack_early: assert property ($fell(accessStrobeN) && req |->
    transferAckN [*4]) else $error("ack too early");
  a_ack_bound: assert property ($fell(accessStrobeN) && req |->
    ##[1:12] !transferAckN) else $error("ack missing");
  a_ack_release: assert property ($rose(accessStrobeN) &&
    !transferAckN |-> ##[1:4] transferAckN) else $error("ack stuck");
  a_ack_stays: assert property (!transferAckN && !accessStrobeN
    |=> !transferAckN) else $error("ack dropped");
  a_drive_ack: assert property (!inputBusOeN |-> !transferAckN)
    else $error("bus driven without ack");
  a_wr_nodrive: assert property ($fell(transferAckN) && !readWrite
    |-> inputBusOeN) else $error("bus driven on write");
  a_idle_noack: assert property ((!conn) [*8] |-> transferAckN)
    else $error("ack outside connect modes");
  a_seq_hold: assert property ((mode == 3'h4 && !readWrite) [*5]
    |=> $stable(outputBus)) else $error("output moved on write");
  a_half_pair: assert property ((mode == 3'h2 && framePulseN) [*6]
    ##0 $changed(outputBus) |=> $stable(outputBus))
    else $error("half rate word held one clock");
  c_read: cover property (!inputBusOeN);
  c_write: cover property ($fell(transferAckN) && !readWrite);
  c_dl_set: cover property (mode == 3'h6 && $fell(accessStrobeN));
endmodule
bind tsm_core tsm_core_checker i_tsm_core_checker (.clk(clk),
  .resetn(resetn), .framePulseN(framePulseN), .modeSelectHi(modeSelectHi),
  .modeSelectMid(modeSelectMid), .modeSelectLo(modeSelectLo),
  .addrBus(addrBus), .readWrite(readWrite), .chipSelectN(chipSelectN),
  .accessStrobeN(accessStrobeN), .inputBus(inputBus),
  .inputBusOut(inputBusOut), .inputBusOeN(inputBusOeN),
  .outputBus(outputBus), .transferAckN(transferAckN));

// File: test/tb_top.sv
// Bench: processor, stream and delay sequences on the switch memory
`timescale 1ns/1ns
`include "tsm_defines.vh"
module tb_top;
  reg         clk = 1'b0;
  reg         resetn = 1'b0;
  reg         framePulseN = 1'b1;
  reg  [2:0]  mode = 3'h0;
  reg  [15:0] strm = 16'h0;
  reg  [15:0] q, d;
  reg  [15:0] smp [0:39];
  reg         ok;
  integer     n_fail = 0, num_checks = 0, cyc = 0, i, j, b, w, lag0;
  wire [15:0] inputBusOut, outputBus, addrBus, dataOut;
  wire        inputBusOeN, transferAckN, chipSelectN, accessStrobeN;
  wire        readWrite, dataDrvN;
  // Block wins while it drives, then the processor, else the stream
  wire [15:0] busLvl = !inputBusOeN ? inputBusOut : !dataDrvN ? dataOut : strm;
  tsm_core i_tsm_core (.clk(clk), .resetn(resetn), .framePulseN(framePulseN),
    .modeSelectHi(mode[2]), .modeSelectMid(mode[1]), .modeSelectLo(mode[0]),
    .addrBus(addrBus), .readWrite(readWrite), .chipSelectN(chipSelectN),
    .accessStrobeN(accessStrobeN), .inputBus(busLvl),
    .inputBusOut(inputBusOut), .inputBusOeN(inputBusOeN),
    .outputBus(outputBus), .transferAckN(transferAckN));
  tsm_proc_model i_tsm_proc_model (.clk(clk), .transferAckN(transferAckN),
    .busIn(busLvl), .chipSelectN(chipSelectN), .accessStrobeN(accessStrobeN),
    .readWrite(readWrite), .addrBus(addrBus), .dataOut(dataOut),
    .dataDrvN(dataDrvN));
  always #10 clk = ~clk;
  // Planned traffic is about 20000 cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  end
  task end_of_test;
    begin
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [15:0] e, s);
    begin
      num_checks = num_checks + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("ERROR %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task step(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task pn(input cs, ds, rw, input [15:0] a);
    i_tsm_proc_model.pins(cs, ds, rw, a);
  endtask
  task acc(input rw, input integer a, h);
    i_tsm_proc_model.access(rw, a[15:0], 16'h5a00 + a[15:0], h, q, ok);
  endtask
  // Frame restarts the counter; the known words must follow in order
  task scan(input integer stp);
    begin
      step(1);
      framePulseN = 1'b0;
      step(1);
      framePulseN = 1'b1;
      for (j = 0; j < 40; j = j + 1) begin
        step(1);
        smp[j] = outputBus;
      end
      b = 32;
      for (j = 31; j >= 0; j = j - 1)
        if (smp[j] === 16'h5a00) b = j;
      w = stp + 2;
      chk("frame", w[15:0], b[15:0]);
      for (j = 0; j < 4 * stp; j = j + 1) begin
        w = 16'h5a00 + j / stp;
        chk("stream", w[15:0], smp[b + j]);
      end
    end
  endtask
  // Frame, then one word per two-clock timeslot: channel c gets base+c
  task ramp(input integer base);
    begin
      step(1);
      framePulseN = 1'b0;
      step(1);
      framePulseN = 1'b1;
      for (j = 0; j < 40; j = j + 1) begin
        step(1);
        w = base + j / 2;
        strm = w[15:0];
      end
    end
  endtask
  // Lag is measured against the zero setting, so sync latency cancels
  task dl(input cs, input integer s, e);
    begin
      pn(cs, 1'b1, 1'b1, s[15:0]);
      pn(cs, 1'b0, 1'b1, s[15:0]);
      pn(1'b1, 1'b1, 1'b1, s[15:0]);
      for (j = 0; j < 4300; j = j + 1) begin
        step(1);
        strm = j[15:0];
      end
      d = strm - outputBus;
      if (e == 0) lag0 = d;
      w = lag0 + 2 * e;
      chk("delay", w[15:0], d);
    end
  endtask
  initial begin
    step(8);
    chk("reset", 16'h3, {14'h0, transferAckN, inputBusOeN});
    chk("reset", 16'h0, outputBus);
    resetn = 1'b1;
    mode = `TSM_MODE_FULL_CONN;
    step(4);
    for (i = 0; i < 4; i = i + 1) begin
      acc(1'b0, i, 0);
      chk("wrAck", 16'h1, {15'h0, ok});
    end
    scan(1);
    mode = `TSM_MODE_HALF_CONN;
    step(4);
    for (i = 0; i < 4; i = i + 1) begin
      acc(1'b1, i, i);
      chk("rdData", 16'h5a00 + i[15:0], q);
    end
    scan(2);
    mode = `TSM_MODE_RANDOM;
    step(4);
    acc(1'b1, 0, 0);
    chk("noAck", 16'h0, {15'h0, ok});
    for (i = 0; i < 4; i = i + 1) begin
      pn(1'b1, 1'b1, 1'b0, 16'h0010 + i[15:0]);
      strm = 16'h7700 + i[15:0];
    end
    for (i = 0; i < 4; i = i + 1) begin
      pn(1'b1, 1'b1, 1'b1, 16'h0010 + i[15:0]);
      step(5);
      chk("random", 16'h7700 + i[15:0], outputBus);
    end
    mode = `TSM_MODE_SEQUENTIAL;
    pn(1'b1, 1'b1, 1'b0, 16'h0);
    for (i = 0; i < 2100; i = i + 1) begin
      step(1);
      strm = 16'h1000 + i[15:0];
    end
    pn(1'b1, 1'b1, 1'b1, 16'h0);
    step(6);
    for (i = 0; i < 8; i = i + 1) begin
      d = outputBus + 16'h1;
      step(1);
      chk("seqRead", d, outputBus);
    end
    mode = `TSM_MODE_LOW_DELAY;
    ramp(16'h6100);
    pn(1'b1, 1'b1, 1'b1, 16'h0005);
    step(8);
    chk("lowDly", 16'h6105, outputBus);
    mode = `TSM_MODE_VAR_RATE;
    ramp(16'h6700);
    pn(1'b1, 1'b1, 1'b1, 16'h0009);
    step(8);
    chk("varRate", 16'h6709, outputBus);
    mode = `TSM_MODE_BANKED;
    ramp(16'h6200);
    ramp(16'h6300);
    step(8);
    chk("banked", 16'h6209, outputBus);
    mode = `TSM_MODE_DELAY_LINE;
    dl(1'b0, 0, 0);
    dl(1'b0, 3, 3);
    dl(1'b1, 9, 3);
    dl(1'b0, 2047, 2047);
    end_of_test;
  end
endmodule
